// ===== cfsc_map.svh
// Constants for the clock fan-out serial configuration block
`ifndef CFSC_MAP_SVH
`define CFSC_MAP_SVH
`define CFSC_SHIFT_LEN       11
`define CFSC_NUM_PAIRS       10
`define CFSC_SEL_BIT         10
`define CFSC_SYS_PERIOD_PS   5000
`define CFSC_CFG_MIN_PER_PS  10000
`define CFSC_HALF_DIV        ((`CFSC_CFG_MIN_PER_PS + 2 * `CFSC_SYS_PERIOD_PS - 1) / (2 * `CFSC_SYS_PERIOD_PS))
`define CFSC_ADDR_CTRL       12'h000
`define CFSC_ADDR_DATA       12'h004
`define CFSC_ADDR_STAT       12'h008
`define CFSC_ADDR_DIV        12'h00C
`define CFSC_CTRL_GO         0
`define CFSC_CTRL_RESET      1
`define CFSC_CTRL_PROG       2
`define CFSC_CTRL_STDSEL     3
`define CFSC_STAT_BUSY       0
`endif

// ===== cfsc_pkg.sv
// Types for the two ends of the serial configuration link, one state type per end
package cfsc_pkg;
    typedef enum logic [1:0] {
        CFSC_IDLE  = 2'b00,
        CFSC_SHIFT = 2'b01,
        CFSC_LOAD  = 2'b10,
        CFSC_DONE  = 2'b11
    } cfsc_seq_t;

    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_LOW  = 2'b01,
        CTL_HIGH = 2'b10
    } cfsc_ctl_t;
endpackage : cfsc_pkg

// ===== cfsc_link_if.sv
// Pin-level link between controller and fan-out device
`timescale 1ns/10ps
interface cfsc_link_if;
    logic programEnable;
    logic configShiftClock;
    logic serialIn;

    modport device (
        input programEnable,
        input configShiftClock,
        input serialIn
    );
    modport controller (
        output programEnable,
        output configShiftClock,
        output serialIn
    );
endinterface : cfsc_link_if

// ===== cfsc_sync3.sv
// Three-stage synchroniser with agreement-based rise detection
`timescale 1ns/10ps
module cfsc_sync3 (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut,
    output logic      rise
);
    logic s1Q;
    logic s2Q;
    logic s3Q;
    logic agreeQ;

    // Only the second and third stages look at the level
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1Q    <= 1'b0;
            s2Q    <= 1'b0;
            s3Q    <= 1'b0;
            agreeQ <= 1'b0;
        end
        else if (clkEn)
        begin
            s1Q <= asyncIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q)
            begin
                agreeQ <= s3Q;
            end
        end
    end

    assign syncOut = agreeQ;
    assign rise    = clkEn && (s2Q == s3Q) && s3Q && !agreeQ;
endmodule : cfsc_sync3

// ===== cfsc_device.sv
// Fan-out device end: serial configuration shift and control registers
`timescale 1ns/10ps
`include "cfsc_map.svh"
module cfsc_device #(
    parameter int NUM_PAIRS = `CFSC_NUM_PAIRS,
    parameter int SHIFT_LEN = `CFSC_SHIFT_LEN
) (
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire logic                 clkEn,
    cfsc_link_if.device               link,
    input  wire logic                 clockInputZero,
    input  wire logic                 clockInputOne,
    output logic [NUM_PAIRS-1:0]      clockOutputPair,
    output logic [NUM_PAIRS-1:0]      pairEnable,
    output logic                      programmedMode,
    output logic                      configLoaded
);
    logic                 ckRise;
    logic                 enLevel;
    logic                 siLevel;
    logic [SHIFT_LEN-1:0] shift_q;
    logic [SHIFT_LEN-1:0] shift_d;
    logic [SHIFT_LEN-1:0] ctrl_q;
    logic [SHIFT_LEN-1:0] ctrl_d;
    logic [3:0]           count_q;
    logic [3:0]           count_d;
    cfsc_pkg::cfsc_seq_t  state_q;
    cfsc_pkg::cfsc_seq_t  state_d;
    logic [NUM_PAIRS-1:0] enable_q;
    logic [NUM_PAIRS-1:0] out_q;
    logic                 prog_q;
    logic                 loaded_q;

    cfsc_sync3 uCk (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .asyncIn (link.configShiftClock),
        .syncOut (),
        .rise    (ckRise)
    );
    cfsc_sync3 uEn (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .asyncIn (link.programEnable),
        .syncOut (enLevel),
        .rise    ()
    );
    cfsc_sync3 uSi (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .asyncIn (link.serialIn),
        .syncOut (siLevel),
        .rise    ()
    );

    // Enable and data lag the clock rise by one stage, so the bit seen
    // at the clock rise is the one the controller set up before it.
    wire resetPulse = ckRise && !enLevel;
    wire shiftPulse = ckRise && enLevel && (state_q == cfsc_pkg::CFSC_SHIFT
                      || state_q == cfsc_pkg::CFSC_IDLE);
    wire loadPulse  = ckRise && enLevel && (state_q == cfsc_pkg::CFSC_LOAD);
    wire lastShift  = (count_q == 4'(SHIFT_LEN - 1));

    always_comb
    begin
        shift_d = shift_q;
        ctrl_d  = ctrl_q;
        count_d = count_q;
        state_d = state_q;
        if (resetPulse)
        begin
            shift_d = '0;
            ctrl_d  = '0;
            count_d = '0;
            state_d = cfsc_pkg::CFSC_IDLE;
        end
        else
        begin
            case (state_q)
                cfsc_pkg::CFSC_IDLE,
                cfsc_pkg::CFSC_SHIFT:
                begin
                    if (shiftPulse)
                    begin
                        // First bit ends in stage 0 after all shifts
                        shift_d = {siLevel, shift_q[SHIFT_LEN-1:1]};
                        count_d = count_q + 4'h1;
                        state_d = lastShift ? cfsc_pkg::CFSC_LOAD
                                            : cfsc_pkg::CFSC_SHIFT;
                    end
                end
                cfsc_pkg::CFSC_LOAD:
                begin
                    if (loadPulse)
                    begin
                        ctrl_d  = shift_q;
                        state_d = cfsc_pkg::CFSC_DONE;
                    end
                end
                cfsc_pkg::CFSC_DONE:
                begin
                    state_d = cfsc_pkg::CFSC_DONE;
                end
                default:
                begin
                    state_d = cfsc_pkg::CFSC_IDLE;
                end
            endcase
        end
    end

    // Shift order: stage k after load is serial bit k, so the
    // first bit (pair nine) lands at index 0 and pair zero at 9.
    wire [NUM_PAIRS-1:0] ctrlEnables;
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++)
        begin : gMap
            assign ctrlEnables[g] = ctrl_q[NUM_PAIRS-1-g];
        end
    endgenerate

    wire stdMode = !enLevel;
    wire [NUM_PAIRS-1:0] enableNext = stdMode ? {NUM_PAIRS{1'b1}}
                                              : ctrlEnables;
    wire selNext   = stdMode ? siLevel : ctrl_q[`CFSC_SEL_BIT];
    wire srcClock  = selNext ? clockInputOne : clockInputZero;
    wire [NUM_PAIRS-1:0] outNext = enableNext & {NUM_PAIRS{srcClock}};

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            shift_q  <= '0;
            ctrl_q   <= '0;
            count_q  <= '0;
            state_q  <= cfsc_pkg::CFSC_IDLE;
            enable_q <= '0;
            out_q    <= '0;
            prog_q   <= 1'b0;
            loaded_q <= 1'b0;
        end
        else if (clkEn)
        begin
            shift_q  <= shift_d;
            ctrl_q   <= ctrl_d;
            count_q  <= count_d;
            state_q  <= state_d;
            enable_q <= enableNext;
            out_q    <= outNext;
            prog_q   <= enLevel;
            loaded_q <= (state_d == cfsc_pkg::CFSC_DONE);
        end
    end

    assign clockOutputPair = out_q;
    assign pairEnable      = enable_q;
    assign programmedMode  = prog_q;
    assign configLoaded    = loaded_q;
endmodule : cfsc_device

// ===== cfsc_controller.sv
// Controller end: APB registers driving the serial configuration pins
`timescale 1ns/10ps
`include "cfsc_map.svh"
module cfsc_controller #(
    parameter int SHIFT_LEN = `CFSC_SHIFT_LEN,
    parameter int HALF_DIV  = `CFSC_HALF_DIV
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    cfsc_link_if.controller  link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [SHIFT_LEN-1:0] data_q;
    logic [SHIFT_LEN-1:0] sh_q;
    logic [15:0]          div_q;
    logic [15:0]          cnt_q;
    logic [4:0]           pulses_q;
    logic                 doReset_q;
    logic                 prog_q;
    logic                 stdSel_q;
    logic                 en_q;
    logic                 ck_q;
    logic                 si_q;
    logic [31:0]          rd_q;
    logic                 ready_q;
    logic                 err_q;
    cfsc_pkg::cfsc_ctl_t  st_q;

    wire access  = psel && penable && !ready_q;
    // Writes land on the edge where pready is sampled high
    wire wr      = psel && penable && ready_q && pwrite;
    wire hitCtrl = (paddr == `CFSC_ADDR_CTRL);
    wire hitData = (paddr == `CFSC_ADDR_DATA);
    wire hitStat = (paddr == `CFSC_ADDR_STAT);
    wire hitDiv  = (paddr == `CFSC_ADDR_DIV);
    wire hitAny  = hitCtrl || hitData || hitStat || hitDiv;
    wire busy    = (st_q != cfsc_pkg::CTL_IDLE);
    wire start   = wr && hitCtrl && !busy && pwdata[`CFSC_CTRL_GO];
    wire tick    = (cnt_q == 16'h0000);
    // Total pulses: one reset, or eleven shifts plus one load
    wire [4:0] lastPulse = 5'(SHIFT_LEN);

    wire [31:0] rdNext;
    assign rdNext = hitCtrl ? {28'h000_0000, stdSel_q, prog_q, 2'b00}
                  : hitData ? {{(32-SHIFT_LEN){1'b0}}, data_q}
                  : hitStat ? {31'h0000_0000, busy}
                  : hitDiv  ? {16'h0000, div_q}
                  : 32'h0000_0000;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            data_q    <= '0;
            sh_q      <= '0;
            div_q     <= 16'(HALF_DIV);
            cnt_q     <= 16'h0000;
            pulses_q  <= 5'h00;
            doReset_q <= 1'b0;
            prog_q    <= 1'b0;
            stdSel_q  <= 1'b0;
            en_q      <= 1'b0;
            ck_q      <= 1'b0;
            si_q      <= 1'b0;
            rd_q      <= 32'h0000_0000;
            ready_q   <= 1'b0;
            err_q     <= 1'b0;
            st_q      <= cfsc_pkg::CTL_IDLE;
        end
        else if (clkEn)
        begin
            ready_q <= access;
            err_q   <= access && !hitAny;
            if (access && !pwrite)
            begin
                rd_q <= rdNext;
            end
            if (wr && hitData && !busy)
            begin
                data_q <= pwdata[SHIFT_LEN-1:0];
            end
            if (wr && hitDiv && !busy)
            begin
                div_q <= (pwdata[15:0] < 16'(HALF_DIV)) ? 16'(HALF_DIV) : pwdata[15:0];
            end
            if (wr && hitCtrl && !busy)
            begin
                prog_q   <= pwdata[`CFSC_CTRL_PROG];
                stdSel_q <= pwdata[`CFSC_CTRL_STDSEL];
            end
            case (st_q)
                cfsc_pkg::CTL_IDLE:
                begin
                    ck_q <= 1'b0;
                    en_q <= prog_q;
                    si_q <= prog_q ? 1'b0 : stdSel_q;
                    if (start)
                    begin
                        doReset_q <= pwdata[`CFSC_CTRL_RESET];
                        en_q      <= !pwdata[`CFSC_CTRL_RESET];
                        // Pair nine enable goes out first
                        sh_q      <= data_q;
                        si_q      <= data_q[0];
                        pulses_q  <= 5'h00;
                        cnt_q     <= div_q;
                        st_q      <= cfsc_pkg::CTL_LOW;
                    end
                end
                cfsc_pkg::CTL_LOW:
                begin
                    if (tick)
                    begin
                        ck_q  <= 1'b1;
                        cnt_q <= div_q;
                        st_q  <= cfsc_pkg::CTL_HIGH;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                cfsc_pkg::CTL_HIGH:
                begin
                    if (tick)
                    begin
                        ck_q <= 1'b0;
                        cnt_q <= div_q;
                        if (doReset_q || pulses_q == lastPulse)
                        begin
                            en_q <= prog_q;
                            st_q <= cfsc_pkg::CTL_IDLE;
                        end
                        else
                        begin
                            pulses_q <= pulses_q + 5'h01;
                            sh_q     <= {1'b0, sh_q[SHIFT_LEN-1:1]};
                            si_q     <= sh_q[1];
                            st_q     <= cfsc_pkg::CTL_LOW;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default:
                begin
                    st_q <= cfsc_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    assign link.programEnable    = en_q;
    assign link.configShiftClock = ck_q;
    assign link.serialIn         = si_q;
    assign prdata                = rd_q;
    assign pready                = ready_q;
    assign pslverr               = err_q;
endmodule : cfsc_controller

// ===== cfsc_link_sva.sv
// Protocol checker watching the serial configuration link pins
`timescale 1ns/10ps
module cfsc_link_sva (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic programEnable,
    input wire logic configShiftClock,
    input wire logic serialIn
);
    logic       ckPrev_q;
    logic [3:0] burstCnt_q;
    logic [3:0] burstCnt_d;
    wire        ckRise = configShiftClock & ~ckPrev_q;
    wire        burstEnd = (burstCnt_q == 4'hB);

    // Counts pulses of a programming burst, twelve to a burst
    assign burstCnt_d = !ckRise ? burstCnt_q :
                        !programEnable ? 4'h0 :
                        burstEnd ? 4'h0 : burstCnt_q + 4'h1;

    always_ff @(posedge sys_clk)
    begin
        ckPrev_q   <= srst ? 1'b0 : configShiftClock;
        burstCnt_q <= srst ? 4'h0 : burstCnt_d;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_ck_high_min: assert property ($rose(configShiftClock) |=> configShiftClock)
        else $error("link clock high for one cycle only");
    a_ck_low_min: assert property ($fell(configShiftClock) |=> !configShiftClock)
        else $error("link clock low for one cycle only");
    a_si_stable: assert property (configShiftClock |-> $stable(serialIn))
        else $error("serial data moved while link clock high");
    a_pe_stable: assert property (configShiftClock |-> $stable(programEnable))
        else $error("program enable moved while link clock high");
    a_burst_cont: assert property (ckRise && programEnable && !burstEnd |-> ##[3:40] ckRise)
        else $error("programming burst stopped short");
    a_burst_whole: assert property (($fell(programEnable) || (ckRise && !programEnable))
                                    |-> burstCnt_q == 4'h0)
        else $error("programming burst not a whole twelve pulses");
    a_rst_single: assert property (ckRise && !programEnable |->
                                   ##[1:40] $fell(configShiftClock) ##1 !configShiftClock [*3])
        else $error("reset pulse not a single pulse");
    a_idle_rst: assert property ($fell(srst) |-> !configShiftClock && !programEnable)
        else $error("link not idle in standard mode after reset");

    c_load: cover property (ckRise && programEnable && burstEnd);
    c_reset: cover property (ckRise && !programEnable);
    c_std: cover property ($fell(programEnable));
endmodule : cfsc_link_sva

// ===== testbench.sv
// Self-checking bench joining controller and device ends over the link
`timescale 1ns/10ps
`include "cfsc_map.svh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clockInputZero = 1'b0;
    logic        clockInputOne = 1'b0;
    logic [9:0]  clockOutputPair;
    logic [9:0]  pairEnable;
    logic        programmedMode;
    logic        configLoaded;
    int          num_errors = 0;
    int          tests_run = 0;

    cfsc_link_if link ();

    always #2.5 sys_clk = ~sys_clk;

    cfsc_controller i_cfsc_controller (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cfsc_device i_cfsc_device (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1), .link(link),
        .clockInputZero(clockInputZero), .clockInputOne(clockInputOne),
        .clockOutputPair(clockOutputPair), .pairEnable(pairEnable),
        .programmedMode(programmedMode), .configLoaded(configLoaded));
    cfsc_link_sva i_cfsc_link_sva (.sys_clk(sys_clk), .srst(srst),
        .programEnable(link.programEnable), .configShiftClock(link.configShiftClock),
        .serialIn(link.serialIn));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: %s got %h", $time, msg, got);
            num_errors++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0000_0000, pready}, 32'h0000_0001, "no bus answer");
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp, "read data");
        chk({31'h0000_0000, e}, {31'h0000_0000, expErr}, "bus error flag");
    endtask : rd

    task automatic wait_idle();
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do
        begin
            apb(1'b0, `CFSC_ADDR_STAT, 32'h0000_0000, r, e);
            n++;
        end
        while (r[`CFSC_STAT_BUSY] !== 1'b0 && n < 100);
        chk({31'h0000_0000, r[`CFSC_STAT_BUSY]}, 32'h0000_0000, "sequence never ends");
        // Device sees pins through a synchroniser, so let it settle
        repeat (12) @(posedge sys_clk);
    endtask : wait_idle

    task automatic check_reset();
        rd(`CFSC_ADDR_STAT, 32'h0000_0000, 1'b0);
        rd(`CFSC_ADDR_DIV, 32'h0000_0001, 1'b0);
        rd(12'h010, 32'h0000_0000, 1'b1);
        wr(`CFSC_ADDR_DIV, 32'h0000_0004);
        rd(`CFSC_ADDR_DIV, 32'h0000_0004, 1'b0);
        chk({31'h0000_0000, configLoaded}, 32'h0000_0000, "loaded after reset");
    endtask : check_reset

    task automatic std_mode();
        clockInputZero <= 1'b1;
        clockInputOne  <= 1'b0;
        wr(`CFSC_ADDR_CTRL, 32'h0000_0000);
        repeat (12) @(posedge sys_clk);
        chk({22'h00_0000, pairEnable}, 32'h0000_03FF, "std enables");
        chk({31'h0000_0000, programmedMode}, 32'h0000_0000, "std mode flag");
        chk({22'h00_0000, clockOutputPair}, 32'h0000_03FF, "std input zero");
        wr(`CFSC_ADDR_CTRL, 32'h0000_0008);
        repeat (12) @(posedge sys_clk);
        chk({22'h00_0000, clockOutputPair}, 32'h0000_0000, "std input one");
    endtask : std_mode

    task automatic program_cfg(input logic [10:0] pat);
        logic [9:0] expEn;
        for (int n = 0; n < 10; n++)
            expEn[n] = pat[9 - n];
        wr(`CFSC_ADDR_CTRL, 32'h0000_0003);
        wait_idle();
        chk({31'h0000_0000, configLoaded}, 32'h0000_0000, "reset pulse");
        wr(`CFSC_ADDR_DATA, {21'h00_0000, pat});
        clockInputZero <= ~pat[10];
        clockInputOne  <= pat[10];
        wr(`CFSC_ADDR_CTRL, 32'h0000_0005);
        wait_idle();
        chk({31'h0000_0000, configLoaded}, 32'h0000_0001, "not loaded");
        chk({31'h0000_0000, programmedMode}, 32'h0000_0001, "prog mode flag");
        chk({22'h00_0000, pairEnable}, {22'h00_0000, expEn}, "pair enables");
        chk({22'h00_0000, clockOutputPair}, {22'h00_0000, expEn}, "pair outputs");
        // Second burst without a reset must not land
        wr(`CFSC_ADDR_DATA, {21'h00_0000, ~pat});
        wr(`CFSC_ADDR_CTRL, 32'h0000_0005);
        wait_idle();
        chk({22'h00_0000, pairEnable}, {22'h00_0000, expEn}, "reloaded");
    endtask : program_cfg

    task automatic back_std();
        wr(`CFSC_ADDR_CTRL, 32'h0000_0000);
        repeat (12) @(posedge sys_clk);
        chk({22'h00_0000, pairEnable}, 32'h0000_03FF, "std after prog");
        chk({31'h0000_0000, programmedMode}, 32'h0000_0000, "mode after prog");
    endtask : back_std

    task automatic report_and_stop();
        $display("errors %0d in %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        check_reset();
        std_mode();
        program_cfg(11'h5A5);
        program_cfg(11'h2C1);
        back_std();
        report_and_stop();
    end

    initial
    begin
        #100000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : testbench
